// ### hw/sas_pkg.sv
// Package for the security access supervisor: map, layouts, reset values
package sas_pkg;

  // Register word offsets (byte addresses on the Avalon-MM slave)
  localparam logic [7:0] OFF_EVT_STATUS = 8'h00;
  localparam logic [7:0] OFF_EVT_REACT  = 8'h04;
  localparam logic [7:0] OFF_FAULT_STAT = 8'h08;
  localparam logic [7:0] OFF_BOOT_CTRL  = 8'h0C;
  localparam logic [7:0] OFF_LIFECYCLE  = 8'h10;
  localparam logic [7:0] OFF_AUTH_KEY   = 8'h14;
  localparam logic [7:0] OFF_OPR_SEL    = 8'h18;
  localparam logic [7:0] OFF_FLASH_WP   = 8'h1C;
  localparam logic [7:0] OFF_PART_BASE  = 8'h40;
  localparam logic [7:0] OFF_PART_ATTR  = 8'h80;

  // Register index field width within the map
  localparam int unsigned REG_ADDR_W = 8;

  // Reset values
  localparam logic [31:0] RST_EVT_REACT  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_OPR_SEL    = 32'h0000_0000;
  localparam logic [31:0] RST_FLASH_WP   = 32'h0000_0001;
  localparam logic [31:0] RST_PART_BASE  = 32'h0000_0000;
  localparam logic [31:0] RST_PART_LIMIT = 32'h0000_0000;
  localparam logic [1:0]  RST_PART_ATTR  = 2'h0;
  localparam logic        RST_BOOT_FLASH = 1'b0;

  // Attribute bit positions
  localparam int unsigned ATTR_USER_RD = 0;
  localparam int unsigned ATTR_USER_WR = 1;

  // Fault status bit positions
  localparam int unsigned FLT_PROHIB  = 0;
  localparam int unsigned FLT_INVALID = 1;
  localparam int unsigned FLT_EXEC    = 2;
  localparam int unsigned FLT_FWP     = 3;
  localparam int unsigned FLT_SFR     = 4;
  localparam int unsigned FLT_TRACE   = 5;

  // Address map of memories seen on the core bus
  localparam logic [31:0] MASK_BASE  = 32'h0000_0000;
  localparam logic [31:0] MASK_LIM   = 32'h0000_FFFF;
  localparam logic [31:0] FLASH_BASE = 32'h1000_0000;
  localparam logic [31:0] FLASH_LIM  = 32'h100F_FFFF;
  localparam logic [31:0] RAM_BASE   = 32'h2000_0000;
  localparam logic [31:0] RAM_LIM    = 32'h2000_3FFF;
  localparam logic [31:0] TRACE_BASE = 32'h100F_F000;
  localparam logic [31:0] TRACE_LIM  = 32'h100F_FFFF;
  localparam logic [31:0] BOOT_MASK_VEC  = 32'h0000_0000;
  localparam logic [31:0] BOOT_FLASH_VEC = 32'h1000_0000;

  // Mask-memory region granule for the region selector: 16 regions
  localparam int unsigned OPR_SHIFT = 12;

  // Lifecycle states
  typedef enum logic [1:0] {
    SAS_LC_TEST_LOCKED,
    SAS_LC_TEST_OPEN,
    SAS_LC_NORMAL
  } sas_lc_e;

  // One core memory access under check
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        fetch;
    logic        priv;
    logic [31:0] addr;
  } sas_mreq_s;

  // Verdict returned in the same cycle
  typedef struct packed {
    logic grant;
    logic fault;
  } sas_mrsp_s;

endpackage : sas_pkg

// ### hw/sas_top.sv
// Security access supervisor: detectors, partitions, boot select, lifecycle
`timescale 1ns/1ps
module sas_top #(
  parameter int unsigned       N_DET    = 8,
  parameter int unsigned       N_PART   = 4,
  parameter logic [31:0]       AUTH_KEY = 32'h5A5A_C3C3 // Arbitrary value
) (
  input  wire logic                 CLOCK_I,
  input  wire logic                 RSTN_I,
  input  wire logic [N_DET-1:0]     DET_EVENT_I,
  input  wire logic                 PHYS_ATTACK_I,
  input  wire logic                 MEM_REQ_I,
  input  wire logic                 MEM_WR_I,
  input  wire logic                 MEM_FETCH_I,
  input  wire logic                 MEM_PRIV_I,
  input  wire logic [31:0]          MEM_ADDR_I,
  output logic                      MEM_GRANT_O,
  output logic                      MEM_FAULT_O,
  input  wire logic [7:0]           AVS_ADDRESS_I,
  input  wire logic                 AVS_READ_I,
  input  wire logic                 AVS_WRITE_I,
  input  wire logic [31:0]          AVS_WRITEDATA_I,
  input  wire logic                 AVS_PRIV_I,
  output logic [31:0]               AVS_READDATA_O,
  output logic                      AVS_WAITREQUEST_O,
  output logic [1:0]                AVS_RESPONSE_O,
  output logic                      CHIP_RESET_O,
  output logic                      HALT_O,
  output logic [31:0]               BOOT_VECTOR_O,
  output logic                      TEST_MODE_O
);

  // Partition sets: low half cover flash, high half cover RAM
  localparam int unsigned NP2 = 2 * N_PART;
  // Top address bit of the mask-region index; 16 regions need four bits
  localparam int unsigned OPR_IDX_HI = sas_pkg::OPR_SHIFT + 3;

  typedef struct packed {
    logic [N_DET-1:0]        det_m;
    logic [N_DET-1:0]        det_s;
    logic [N_DET-1:0]        evt;
    logic [N_DET-1:0]        react;
    logic [5:0]              fault;
    logic                    boot_flash;
    logic                    boot_lock;
    sas_pkg::sas_lc_e        lc;
    logic [31:0]             opr_sel;
    logic                    fwp;
    logic [NP2-1:0][31:0]    base;
    logic [NP2-1:0][31:0]    limit;
    logic [NP2-1:0][1:0]     attr;
    logic                    atk_m;
    logic                    atk_s;
    logic                    halt;
    logic                    chip_rst;
    logic                    grant;
    logic                    mfault;
    logic                    waitreq;
    logic [31:0]             rdata;
    logic [1:0]              resp;
    logic                    test_mode;
    logic [31:0]             boot_vec;
  } sas_state_s;

  sas_state_s  s_q;
  sas_state_s  s_d;
  logic [N_DET-1:0] det_m3_q;
  logic        atk_m3_q;
  sas_pkg::sas_mreq_s mreq;
  sas_pkg::sas_mrsp_s mrsp;

  // Inclusive window test used by every partition and memory range
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Security registers need privilege; event and fault status are readable without it
  function automatic logic sfr_allowed(input logic [7:0] a, input logic priv,
                                       input logic wr);
    sfr_allowed = priv || (!wr && (a == sas_pkg::OFF_EVT_STATUS ||
                                   a == sas_pkg::OFF_FAULT_STAT));
  endfunction : sfr_allowed

  assign mreq = '{req: MEM_REQ_I, wr: MEM_WR_I, fetch: MEM_FETCH_I,
                  priv: MEM_PRIV_I, addr: MEM_ADDR_I};

  // Third stage of the pin synchronisers; reads only the second stage
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      det_m3_q <= '0;
      atk_m3_q <= 1'b0;
    end else begin
      det_m3_q <= s_q.det_s;
      atk_m3_q <= s_q.atk_s;
    end
  end

  // Memory access verdict, evaluated combinationally from the request
  always_comb begin
    logic       in_mask;
    logic       in_flash;
    logic       in_ram;
    logic       hit;
    logic [1:0] at;
    logic       deny;
    in_mask  = in_range(mreq.addr, sas_pkg::MASK_BASE, sas_pkg::MASK_LIM);
    in_flash = in_range(mreq.addr, sas_pkg::FLASH_BASE, sas_pkg::FLASH_LIM);
    in_ram   = in_range(mreq.addr, sas_pkg::RAM_BASE, sas_pkg::RAM_LIM);
    hit      = 1'b0;
    at       = 2'h0;
    // First matching partition of the right memory wins
    for (int i = NP2 - 1; i >= 0; i--) begin
      if (((i < N_PART) ? in_flash : in_ram) &&
          in_range(mreq.addr, s_q.base[i], s_q.limit[i])) begin
        hit = 1'b1;
        at  = s_q.attr[i];
      end
    end
    deny = 1'b0;
    mrsp.fault = 1'b0;
    if (!(in_mask || in_flash || in_ram)) begin
      deny = 1'b1;
    end else if (!mreq.priv) begin
      if (in_mask) begin
        deny = !s_q.opr_sel[mreq.addr[OPR_IDX_HI:sas_pkg::OPR_SHIFT]];
      end else begin
        // User mode outside any partition is prohibited
        deny = !hit || (mreq.wr ? !at[sas_pkg::ATTR_USER_WR]
                                : !at[sas_pkg::ATTR_USER_RD]);
      end
    end
    if (in_mask && mreq.wr) begin
      deny = 1'b1;
    end
    if (in_flash && mreq.wr && s_q.fwp) begin
      deny = 1'b1;
    end
    if (mreq.wr && s_q.lc == sas_pkg::SAS_LC_NORMAL &&
        in_range(mreq.addr, sas_pkg::TRACE_BASE, sas_pkg::TRACE_LIM)) begin
      deny = 1'b1;
    end
    // A halted core still gets an answer: every request is trapped
    mrsp.fault = mreq.req && (deny || s_q.halt);
    mrsp.grant = mreq.req && !deny && !s_q.halt;
  end

  // Next state: detectors, bus slave, lifecycle, verdict registers
  always_comb begin
    logic [7:0] a;
    logic       acc;
    logic       ok;
    logic       mapped;
    logic [31:0] rd;
    s_d    = s_q;
    a      = AVS_ADDRESS_I;
    acc    = (AVS_READ_I || AVS_WRITE_I) && s_q.waitreq;
    ok     = sfr_allowed(a, AVS_PRIV_I, AVS_WRITE_I);
    mapped = 1'b1;
    rd     = 32'h0000_0000;
    // Synchronise detector and shield pins; nothing can gate them
    s_d.det_m = DET_EVENT_I;
    s_d.det_s = s_q.det_m;
    s_d.atk_m = PHYS_ATTACK_I;
    s_d.atk_s = s_q.atk_m;
    // Read mux
    case (a)
      sas_pkg::OFF_EVT_STATUS: rd = 32'(s_q.evt);
      sas_pkg::OFF_EVT_REACT:  rd = 32'(s_q.react);
      sas_pkg::OFF_FAULT_STAT: rd = 32'(s_q.fault);
      sas_pkg::OFF_BOOT_CTRL:  rd = {30'h0, s_q.boot_lock, s_q.boot_flash};
      sas_pkg::OFF_LIFECYCLE:  rd = 32'(s_q.lc);
      sas_pkg::OFF_AUTH_KEY:   rd = 32'h0000_0000;
      sas_pkg::OFF_OPR_SEL:    rd = s_q.opr_sel;
      sas_pkg::OFF_FLASH_WP:   rd = {31'h0, s_q.fwp};
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < NP2; i++) begin
          if (a == sas_pkg::OFF_PART_BASE + 8'(8 * i)) begin
            rd = s_q.base[i];
            mapped = 1'b1;
          end
          if (a == sas_pkg::OFF_PART_BASE + 8'(8 * i + 4)) begin
            rd = s_q.limit[i];
            mapped = 1'b1;
          end
          if (a == sas_pkg::OFF_PART_ATTR + 8'(4 * i)) begin
            rd = {30'h0, s_q.attr[i]};
            mapped = 1'b1;
          end
        end
      end
    endcase
    // Answer one cycle after the request, then re-arm waitrequest
    s_d.waitreq = 1'b1;
    s_d.resp    = 2'h0;
    if (acc) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = (ok && mapped && AVS_READ_I) ? rd : 32'h0000_0000;
      s_d.resp    = (ok && mapped) ? 2'h0 : 2'h2;
    end else if (!s_q.waitreq) begin
      s_d.rdata = 32'h0000_0000;
    end
    // Register writes, only when granted
    if (acc && AVS_WRITE_I && ok && mapped) begin
      case (a)
        sas_pkg::OFF_EVT_STATUS: s_d.evt = s_q.evt & ~AVS_WRITEDATA_I[N_DET-1:0];
        sas_pkg::OFF_EVT_REACT:  s_d.react = AVS_WRITEDATA_I[N_DET-1:0];
        sas_pkg::OFF_FAULT_STAT: s_d.fault = s_q.fault & ~AVS_WRITEDATA_I[5:0];
        sas_pkg::OFF_BOOT_CTRL: begin
          if (!s_q.boot_lock) begin
            s_d.boot_flash = AVS_WRITEDATA_I[0];
            s_d.boot_lock  = AVS_WRITEDATA_I[1];
          end
        end
        sas_pkg::OFF_LIFECYCLE: begin
          if (AVS_WRITEDATA_I[0]) begin
            s_d.lc = sas_pkg::SAS_LC_NORMAL;
          end
        end
        sas_pkg::OFF_AUTH_KEY: begin
          if (s_q.lc == sas_pkg::SAS_LC_TEST_LOCKED && AVS_WRITEDATA_I == AUTH_KEY) begin
            s_d.lc = sas_pkg::SAS_LC_TEST_OPEN;
          end
        end
        sas_pkg::OFF_OPR_SEL:  s_d.opr_sel = AVS_WRITEDATA_I;
        sas_pkg::OFF_FLASH_WP: s_d.fwp = AVS_WRITEDATA_I[0];
        default: begin
          for (int i = 0; i < NP2; i++) begin
            if (a == sas_pkg::OFF_PART_BASE + 8'(8 * i)) begin
              s_d.base[i] = AVS_WRITEDATA_I;
            end
            if (a == sas_pkg::OFF_PART_BASE + 8'(8 * i + 4)) begin
              s_d.limit[i] = AVS_WRITEDATA_I;
            end
            if (a == sas_pkg::OFF_PART_ATTR + 8'(4 * i)) begin
              s_d.attr[i] = AVS_WRITEDATA_I[1:0];
            end
          end
        end
      endcase
    end
    // Normal mode is sticky: no write path leaves it
    if (s_q.lc == sas_pkg::SAS_LC_NORMAL) begin
      s_d.lc = sas_pkg::SAS_LC_NORMAL;
    end
    // Events set after the clear so a same-cycle event survives
    for (int i = 0; i < N_DET; i++) begin
      if (s_q.det_s[i] && det_m3_q[i]) begin
        s_d.evt[i] = 1'b1;
      end
    end
    // Reaction: reset held while an event bit is set for a detector set to reset; attack always halts
    s_d.chip_rst = |(s_q.evt & s_q.react);
    if (s_q.atk_s && atk_m3_q) begin
      s_d.halt = 1'b1;
    end
    if (s_q.halt) begin
      s_d.chip_rst = 1'b1;
    end
    // Record memory faults, sticky
    if (mrsp.fault) begin
      s_d.fault[sas_pkg::FLT_PROHIB] = 1'b1;
      if (!(in_range(mreq.addr, sas_pkg::MASK_BASE, sas_pkg::MASK_LIM) ||
            in_range(mreq.addr, sas_pkg::FLASH_BASE, sas_pkg::FLASH_LIM) ||
            in_range(mreq.addr, sas_pkg::RAM_BASE, sas_pkg::RAM_LIM))) begin
        s_d.fault[sas_pkg::FLT_INVALID] = 1'b1;
      end
      if (mreq.fetch && in_range(mreq.addr, sas_pkg::FLASH_BASE, sas_pkg::FLASH_LIM)) begin
        s_d.fault[sas_pkg::FLT_EXEC] = 1'b1;
      end
      if (mreq.wr && in_range(mreq.addr, sas_pkg::FLASH_BASE, sas_pkg::FLASH_LIM)) begin
        s_d.fault[sas_pkg::FLT_FWP] = 1'b1;
      end
    end
    if (acc && !(ok && mapped)) begin
      s_d.fault[sas_pkg::FLT_SFR] = 1'b1;
    end
    // Decoded outputs taken from next state so they keep their old timing
    s_d.test_mode = (s_d.lc == sas_pkg::SAS_LC_TEST_OPEN);
    s_d.boot_vec  = s_d.boot_flash ? sas_pkg::BOOT_FLASH_VEC
                                   : sas_pkg::BOOT_MASK_VEC;
    s_d.grant  = mrsp.grant;
    s_d.mfault = mrsp.fault;
  end

  // State register with fixed defaults on reset
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      s_q            <= '0;
      s_q.react      <= sas_pkg::RST_EVT_REACT[N_DET-1:0];
      s_q.opr_sel    <= sas_pkg::RST_OPR_SEL;
      s_q.fwp        <= sas_pkg::RST_FLASH_WP[0];
      s_q.boot_flash <= sas_pkg::RST_BOOT_FLASH;
      s_q.boot_vec   <= sas_pkg::RST_BOOT_FLASH ? sas_pkg::BOOT_FLASH_VEC
                                                : sas_pkg::BOOT_MASK_VEC;
      s_q.lc         <= sas_pkg::SAS_LC_TEST_LOCKED;
      s_q.waitreq    <= 1'b1;
      for (int i = 0; i < NP2; i++) begin
        s_q.base[i]  <= sas_pkg::RST_PART_BASE;
        s_q.limit[i] <= sas_pkg::RST_PART_LIMIT;
        s_q.attr[i]  <= sas_pkg::RST_PART_ATTR;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign MEM_GRANT_O       = s_q.grant;
  assign MEM_FAULT_O       = s_q.mfault;
  assign AVS_READDATA_O    = s_q.rdata;
  assign AVS_WAITREQUEST_O = s_q.waitreq;
  assign AVS_RESPONSE_O    = s_q.resp;
  assign CHIP_RESET_O      = s_q.chip_rst;
  assign HALT_O            = s_q.halt;
  assign TEST_MODE_O       = s_q.test_mode;
  assign BOOT_VECTOR_O     = s_q.boot_vec;

  // Assertions
  normal_sticky_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    s_q.lc == sas_pkg::SAS_LC_NORMAL |=> s_q.lc == sas_pkg::SAS_LC_NORMAL)
    else $error("normal mode left");
  no_test_normal_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    $past(s_q.lc) == sas_pkg::SAS_LC_NORMAL |-> !TEST_MODE_O)
    else $error("test mode after normal");
  fault_no_grant_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    MEM_FAULT_O |-> !MEM_GRANT_O)
    else $error("faulted access granted");
  flash_wp_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    MEM_REQ_I && MEM_WR_I && s_q.fwp && MEM_ADDR_I >= sas_pkg::FLASH_BASE &&
    MEM_ADDR_I <= sas_pkg::FLASH_LIM |=> MEM_FAULT_O && !MEM_GRANT_O)
    else $error("protected flash write passed");
  invalid_addr_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    MEM_REQ_I && MEM_ADDR_I > sas_pkg::RAM_LIM |=> s_q.fault[sas_pkg::FLT_INVALID])
    else $error("invalid address not flagged");
  event_latch_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    s_q.det_s[0] && det_m3_q[0] |=> s_q.evt[0])
    else $error("detector event lost");
  react_reset_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (s_q.evt[0] && s_q.react[0]) |=> CHIP_RESET_O)
    else $error("reset reaction missing");
  attack_halt_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    s_q.halt |=> HALT_O [*2] ##0 CHIP_RESET_O)
    else $error("halt released");
  bus_answer_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (AVS_READ_I || AVS_WRITE_I) |-> ##[0:1] !AVS_WAITREQUEST_O)
    else $error("bus answer late");
  user_sfr_a: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    AVS_WRITE_I && !AVS_PRIV_I && AVS_WAITREQUEST_O |=> AVS_RESPONSE_O == 2'h2)
    else $error("user sfr write accepted");
  cov_fault_c:   cover property (@(posedge CLOCK_I) MEM_FAULT_O);
  cov_normal_c:  cover property (@(posedge CLOCK_I) s_q.lc == sas_pkg::SAS_LC_NORMAL);
  cov_testopn_c: cover property (@(posedge CLOCK_I) TEST_MODE_O);
  cov_reset_c:   cover property (@(posedge CLOCK_I) CHIP_RESET_O);

endmodule : sas_top

// ### dv/sas_core_model.sv
// Core-side model: Avalon-MM master and memory access requester
`timescale 1ns/1ps
module sas_core_model (
  input  wire logic         clk_i,
  input  wire logic         wait_i,
  input  wire logic [31:0]  rdata_i,
  input  wire logic [1:0]   resp_i,
  input  wire logic         grant_i,
  input  wire logic         fault_i,
  output logic [7:0]        adr_o,
  output logic              rd_o,
  output logic              wr_o,
  output logic [31:0]       wdata_o,
  output logic              priv_o,
  output sas_pkg::sas_mreq_s mreq_o
);
  // Idle bus and no access at time zero
  initial begin
    {adr_o, rd_o, wr_o, wdata_o, priv_o} = '0;
    mreq_o = '0;
  end

  // One bus word, held until waitrequest is seen low; a hang is left to the watchdog
  task automatic av(input logic w, input logic p, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    @(posedge clk_i);
    adr_o   <= a;
    wr_o    <= w;
    rd_o    <= !w;
    wdata_o <= d;
    priv_o  <= p;
    do begin
      @(posedge clk_i);
    end while (wait_i !== 1'b0);
    q = rdata_i;
    r = resp_i;
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    wdata_o <= ~d; // Released data must not keep showing the last word
  endtask : av

  // One request cycle; verdict taken from the registered outputs one cycle after it stands
  task automatic mem(input logic w, f, p, input logic [31:0] a, output logic g, t);
    @(posedge clk_i);
    mreq_o <= '{req: 1'b1, wr: w, fetch: f, priv: p, addr: a};
    @(posedge clk_i);
    mreq_o.req  <= 1'b0;
    mreq_o.addr <= ~a;
    @(posedge clk_i);
    g = grant_i;
    t = fault_i;
  endtask : mem
endmodule : sas_core_model

// ### dv/sas_top_bench.sv
// Self-checking bench for the security access supervisor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module sas_top_bench;
  localparam logic [31:0] KEY = 32'h0F1E_2D3C; // Arbitrary value
  // Reaction register holds one bit per detector, eight here
  localparam logic [31:0] REACT_RST = {24'h00_0000, sas_pkg::RST_EVT_REACT[7:0]};
  logic               clk, rstn, attack, gnt, flt, wq, crst, halt, tmode, g, t;
  logic [7:0]         det, adr;
  logic               rd_s, wr_s, pv;
  logic [31:0]        wd, rdat, boot, q, seed;
  logic [1:0]         rsp, r;
  sas_pkg::sas_mreq_s mreq;
  int                 error_cnt = 0;
  int                 total_checks = 0;

  sas_top #(.AUTH_KEY(KEY)) DUT (.CLOCK_I(clk), .RSTN_I(rstn), .DET_EVENT_I(det),
    .PHYS_ATTACK_I(attack), .MEM_REQ_I(mreq.req), .MEM_WR_I(mreq.wr),
    .MEM_FETCH_I(mreq.fetch), .MEM_PRIV_I(mreq.priv), .MEM_ADDR_I(mreq.addr),
    .MEM_GRANT_O(gnt), .MEM_FAULT_O(flt), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_s),
    .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wd), .AVS_PRIV_I(pv), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wq), .AVS_RESPONSE_O(rsp), .CHIP_RESET_O(crst), .HALT_O(halt),
    .BOOT_VECTOR_O(boot), .TEST_MODE_O(tmode));
  sas_core_model m (.clk_i(clk), .wait_i(wq), .rdata_i(rdat), .resp_i(rsp), .grant_i(gnt),
    .fault_i(flt), .adr_o(adr), .rd_o(rd_s), .wr_o(wr_s), .wdata_o(wd), .priv_o(pv),
    .mreq_o(mreq));

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic p, input logic [7:0] a, input logic [31:0] d);
    m.av(1'b1, p, a, d, q, r);
  endtask : wr

  task automatic rd(input logic p, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    m.av(1'b0, p, a, 32'h0, q, r);
    `CHK("readdata", e, q)
    `CHK("response", er, r)
  endtask : rd

  // Fault status bit must be set, then it is cleared for the next case
  task automatic fb(input int b);
    m.av(1'b0, 1'b1, sas_pkg::OFF_FAULT_STAT, 32'h0, q, r);
    `CHK("fault_stat bit", 1'b1, q[b])
    wr(1'b1, sas_pkg::OFF_FAULT_STAT, 32'h0000_003F);
  endtask : fb

  task automatic acc(input logic w, f, p, input logic [31:0] a, input logic ef);
    m.mem(w, f, p, a, g, t);
    `CHK("grant", !ef, g)
    `CHK("fault", ef, t)
  endtask : acc

  task automatic pulse(input logic [7:0] d);
    @(posedge clk);
    det <= d;
    repeat (8) @(posedge clk);
    det <= 8'h00;
    repeat (4) @(posedge clk);
  endtask : pulse

  // Watchdog sized well above the whole sequence
  initial begin
    #40000;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {clk, rstn, attack, det} = '0;
    seed = 32'h0001_6460;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(1'b1, sas_pkg::OFF_EVT_REACT, REACT_RST, 2'h0);
    rd(1'b1, sas_pkg::OFF_FLASH_WP, sas_pkg::RST_FLASH_WP, 2'h0);
    rd(1'b1, sas_pkg::OFF_OPR_SEL, sas_pkg::RST_OPR_SEL, 2'h0);
    rd(1'b1, sas_pkg::OFF_PART_BASE, sas_pkg::RST_PART_BASE, 2'h0);
    rd(1'b1, sas_pkg::OFF_PART_ATTR, 32'h0, 2'h0);
    `CHK("boot_vector", sas_pkg::BOOT_MASK_VEC, boot)
    // Register access by privilege; refused writes leave the register unchanged and set the SFR fault bit
    rd(1'b0, sas_pkg::OFF_EVT_REACT, 32'h0, 2'h2);
    wr(1'b0, sas_pkg::OFF_EVT_REACT, 32'h0);
    rd(1'b1, sas_pkg::OFF_EVT_REACT, REACT_RST, 2'h0);
    fb(sas_pkg::FLT_SFR);
    rd(1'b0, sas_pkg::OFF_EVT_STATUS, 32'h0, 2'h0);
    rd(1'b1, 8'h3C, 32'h0, 2'h2);
    // Detector capture and the two reactions
    wr(1'b1, sas_pkg::OFF_EVT_REACT, 32'h0);
    pulse(8'h04);
    rd(1'b1, sas_pkg::OFF_EVT_STATUS, 32'h4, 2'h0);
    `CHK("chip_reset", 1'b0, crst)
    wr(1'b1, sas_pkg::OFF_EVT_REACT, 32'h4);
    repeat (2) @(posedge clk);
    `CHK("chip_reset", 1'b1, crst)
    wr(1'b1, sas_pkg::OFF_EVT_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    `CHK("chip_reset", 1'b0, crst)
    rd(1'b1, sas_pkg::OFF_EVT_STATUS, 32'h0, 2'h0);
    // Mask memory regions, privilege, invalid and flash write protection
    acc(1'b0, 1'b0, 1'b1, 32'h0000_0010, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 32'h0000_0010, 1'b1);
    wr(1'b1, sas_pkg::OFF_OPR_SEL, 32'h1);
    acc(1'b0, 1'b0, 1'b0, 32'h0000_0FFC, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 32'h0000_1000, 1'b1);
    fb(sas_pkg::FLT_PROHIB);
    acc(1'b1, 1'b0, 1'b1, 32'h0000_0010, 1'b1);
    acc(1'b0, 1'b0, 1'b1, 32'h3000_0000, 1'b1);
    fb(sas_pkg::FLT_INVALID);
    acc(1'b1, 1'b0, 1'b1, sas_pkg::FLASH_BASE, 1'b1);
    fb(sas_pkg::FLT_FWP);
    wr(1'b1, sas_pkg::OFF_FLASH_WP, 32'h0);
    acc(1'b1, 1'b0, 1'b1, sas_pkg::FLASH_BASE, 1'b0);
    // Flash partition 0 read-only for user, RAM partition 4 read-write
    wr(1'b1, sas_pkg::OFF_PART_BASE, 32'h1000_0100);
    wr(1'b1, 8'h44, 32'h1000_01FF);
    wr(1'b1, sas_pkg::OFF_PART_ATTR, 32'h1);
    acc(1'b0, 1'b0, 1'b0, 32'h1000_0100, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 32'h1000_01FF, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 32'h1000_00FF, 1'b1);
    acc(1'b0, 1'b0, 1'b0, 32'h1000_0200, 1'b1);
    acc(1'b1, 1'b0, 1'b0, 32'h1000_0100, 1'b1);
    acc(1'b0, 1'b1, 1'b0, 32'h1000_0200, 1'b1);
    fb(sas_pkg::FLT_EXEC);
    wr(1'b1, 8'h60, sas_pkg::RAM_BASE);
    wr(1'b1, 8'h64, 32'h2000_00FF);
    wr(1'b1, 8'h90, 32'h3);
    acc(1'b1, 1'b0, 1'b0, 32'h2000_0080, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 32'h2000_0100, 1'b1);
    // Lifecycle: key opens test mode, normal mode is one-way
    rd(1'b1, sas_pkg::OFF_LIFECYCLE, 32'h0, 2'h0);
    wr(1'b1, sas_pkg::OFF_AUTH_KEY, ~KEY);
    `CHK("test_mode", 1'b0, tmode)
    wr(1'b1, sas_pkg::OFF_AUTH_KEY, KEY);
    repeat (2) @(posedge clk);
    `CHK("test_mode", 1'b1, tmode)
    acc(1'b1, 1'b0, 1'b1, sas_pkg::TRACE_BASE, 1'b0);
    wr(1'b1, sas_pkg::OFF_LIFECYCLE, 32'h1);
    wr(1'b1, sas_pkg::OFF_AUTH_KEY, KEY);
    rd(1'b1, sas_pkg::OFF_LIFECYCLE, 32'h2, 2'h0);
    `CHK("test_mode", 1'b0, tmode)
    acc(1'b1, 1'b0, 1'b1, sas_pkg::TRACE_BASE, 1'b1);
    wr(1'b1, sas_pkg::OFF_BOOT_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("boot_vector", sas_pkg::BOOT_FLASH_VEC, boot)
    wr(1'b1, sas_pkg::OFF_BOOT_CTRL, 32'h3);
    wr(1'b1, sas_pkg::OFF_BOOT_CTRL, 32'h0);
    rd(1'b1, sas_pkg::OFF_BOOT_CTRL, 32'h3, 2'h0);
    // Random RAM reads, invalid addresses and partition bounds
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      acc(1'b0, 1'b0, 1'b1, {18'h08000, seed[13:2], 2'h0}, 1'b0);
      acc(1'b0, 1'b0, 1'b1, {2'h1, seed[29:0]}, 1'b1);
      wr(1'b1, 8'h68, seed);
      rd(1'b1, 8'h68, seed, 2'h0);
    end
    // Physical attack halts everything until reset
    @(posedge clk);
    attack <= 1'b1;
    repeat (8) @(posedge clk);
    attack <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("halt", 1'b1, halt)
    `CHK("chip_reset", 1'b1, crst)
    acc(1'b0, 1'b0, 1'b1, 32'h0000_0010, 1'b1);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK("halt", 1'b0, halt)
    `CHK("boot_vector", sas_pkg::BOOT_MASK_VEC, boot)
    rd(1'b1, sas_pkg::OFF_EVT_REACT, REACT_RST, 2'h0);
    tally_and_finish();
  end
endmodule : sas_top_bench
